// ==== hdl/pmtmr_params.svh ====
// constants for the power-management timer block
`ifndef PMTMR_PARAMS_SVH
`define PMTMR_PARAMS_SVH

// ----------------------------------------
// i/o offsets from the base pair
// ----------------------------------------
`define PMTMR_OFS_CTL_RSVD_A   16'h0006
`define PMTMR_OFS_CTL_RSVD_B   16'h0007
`define PMTMR_OFS_CNT_LOW      16'h0008
`define PMTMR_OFS_CNT_MID      16'h0009
`define PMTMR_OFS_CNT_HIGH     16'h000a

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PMTMR_CNT_W            24
`define PMTMR_CNT_TOP          23
`define PMTMR_RST_BYTE         8'h00
`define PMTMR_RST_CNT          24'h000000
`define PMTMR_RSVD_VALUE       8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define PMTMR_CLK_HZ           26'd40000000
`define PMTMR_TIMEBASE_HZ      26'd3579545
`define PMTMR_ACC_W            26
// input clock pin declared stopped after this many cycles with no edge
`define PMTMR_CHIP_INPUT_CLOCK_PIN_IDLE_CYC   8'h10

`endif

// ==== hdl/pmtmr_pkg.sv ====
// types shared by the power-management timer block
package pmtmr_pkg;

  // host i/o cycle as seen by the block
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } pmtmr_io_req_t;

  // state of the chip input clock pin monitor
  typedef enum logic {
    PMTMR_CHIP_INPUT_CLOCK_PIN_RUNNING,
    PMTMR_CHIP_INPUT_CLOCK_PIN_STOPPED
  } pmtmr_chip_input_clock_pin_state_t;

endpackage

// ==== hdl/pmtmr_tick.sv ====
// fractional divider giving a timebase enable pulse from the system clock
`timescale 1ns/1ps
`include "pmtmr_params.svh"

module pmtmr_tick (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // control
  input  wire logic run,
  // timebase enable, one cycle
  output logic      tick
);

  logic [`PMTMR_ACC_W-1:0] acc_r;
  logic [`PMTMR_ACC_W:0]   sum;

  // phase accumulator: average rate exact, jitter one system clock
  assign sum  = {1'b0, acc_r} + {1'b0, `PMTMR_TIMEBASE_HZ};
  assign tick = run && (sum >= {1'b0, `PMTMR_CLK_HZ});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= '0;
    end else if (run) begin
      if (tick) begin
        acc_r <= sum[`PMTMR_ACC_W-1:0] - `PMTMR_CLK_HZ;
      end else begin
        acc_r <= sum[`PMTMR_ACC_W-1:0];
      end
    end
  end

endmodule

// ==== hdl/pmtmr_top.sv ====
// power-management timer with its i/o byte registers and sci event
`timescale 1ns/1ps
`include "pmtmr_params.svh"

// How it works
// - a 24-bit up-counter whose live value software may read anytime
// - the counter advances once per 3.579545 MHz timebase cycle
// - counting happens only while the working power state is present
// - after master reset it counts freely until the input clock pin stops
// - on input clock restart without reset, counting resumes from the held value
// - any change of count bit 23 sets the toggle status flag
// - with event enable set, the status flag drives the low sci output
// - offsets 6 and 7 are reserved bytes that always read zero
// - offset 8 from the base returns count bits 7 to 0
// - offset 9 from the base returns count bits 15 to 8
// - offset 0xa from the base returns count bits 23 to 16
module pmtmr_top (
  // clock and master reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // power state and chip input clock pin
  input  wire logic                  working_state,
  input  wire logic                  chip_input_clock_pin,
  // base from the configuration register pair
  input  wire logic [15:0]           pm_base_config_pair,
  // host i/o cycle
  input  wire pmtmr_pkg::pmtmr_io_req_t io_req,
  output logic [7:0]                 io_rdata,
  output logic                       io_rd_hit,
  // event control and status
  input  wire logic                  timer_event_enable,
  input  wire logic                  timer_status_clear,
  output logic                       timer_top_bit_toggle_flag,
  output logic                       sci_b,
  // observation
  output logic [`PMTMR_CNT_W-1:0]    timer_count_value,
  output logic                       chip_clock_stopped
);

  // ----------------------------------------
  // offset decode
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] base,
                               input logic [15:0] ofs);
    hit = (addr == (base + ofs));
  endfunction

  // ----------------------------------------
  // input clock pin monitor
  // ----------------------------------------
  pmtmr_pkg::pmtmr_chip_input_clock_pin_state_t chip_input_clock_pin_state_r;
  logic                          chip_input_clock_pin_q_r;
  logic [7:0]                    idle_cnt_r;
  logic                          chip_input_clock_pin_edge;

  assign chip_input_clock_pin_edge         = chip_input_clock_pin ^ chip_input_clock_pin_q_r;
  assign chip_clock_stopped = (chip_input_clock_pin_state_r == pmtmr_pkg::PMTMR_CHIP_INPUT_CLOCK_PIN_STOPPED);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chip_input_clock_pin_q_r <= 1'b0;
    end else begin
      chip_input_clock_pin_q_r <= chip_input_clock_pin;
    end
  end

  // pin edges restart the idle count; a long silence means the clock stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_r    <= 8'h00;
      chip_input_clock_pin_state_r <= pmtmr_pkg::PMTMR_CHIP_INPUT_CLOCK_PIN_RUNNING;
    end else begin
      unique case (chip_input_clock_pin_state_r)
        pmtmr_pkg::PMTMR_CHIP_INPUT_CLOCK_PIN_RUNNING: begin
          if (chip_input_clock_pin_edge) begin
            idle_cnt_r <= 8'h00;
          end else if (idle_cnt_r == `PMTMR_CHIP_INPUT_CLOCK_PIN_IDLE_CYC - 8'h01) begin
            chip_input_clock_pin_state_r <= pmtmr_pkg::PMTMR_CHIP_INPUT_CLOCK_PIN_STOPPED;
          end else begin
            idle_cnt_r <= idle_cnt_r + 8'h01;
          end
        end
        pmtmr_pkg::PMTMR_CHIP_INPUT_CLOCK_PIN_STOPPED: begin
          if (chip_input_clock_pin_edge) begin
            idle_cnt_r    <= 8'h00;
            chip_input_clock_pin_state_r <= pmtmr_pkg::PMTMR_CHIP_INPUT_CLOCK_PIN_RUNNING;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // timebase and counter
  // ----------------------------------------
  logic run;
  logic tick;
  logic [`PMTMR_CNT_W-1:0] cnt_r;
  logic [`PMTMR_CNT_W-1:0] cnt_nxt;

  assign run = working_state && !chip_clock_stopped;

  pmtmr_tick u_tick (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (run),
    .tick  (tick)
  );

  assign cnt_nxt           = cnt_r + 24'h000001;
  assign timer_count_value = cnt_r;

  // count is held, not cleared, while stopped; only master reset zeroes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= `PMTMR_RST_CNT;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // top-bit toggle status and sci
  // ----------------------------------------
  logic top_toggle;

  assign top_toggle = tick && (cnt_nxt[`PMTMR_CNT_TOP] != cnt_r[`PMTMR_CNT_TOP]);

  // a toggle in the clearing cycle still sets the flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_top_bit_toggle_flag <= 1'b0;
    end else if (top_toggle) begin
      timer_top_bit_toggle_flag <= 1'b1;
    end else if (timer_status_clear) begin
      timer_top_bit_toggle_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sci_b <= 1'b1;
    end else begin
      sci_b <= !(timer_event_enable && (timer_top_bit_toggle_flag || top_toggle));
    end
  end

  // ----------------------------------------
  // i/o read port
  // ----------------------------------------
  logic [7:0] rd_byte;
  logic       rd_sel;

  always_comb begin
    rd_byte = `PMTMR_RSVD_VALUE;
    rd_sel  = 1'b1;
    if (hit(io_req.addr, pm_base_config_pair, `PMTMR_OFS_CNT_LOW)) begin
      rd_byte = cnt_r[7:0];
    end else if (hit(io_req.addr, pm_base_config_pair, `PMTMR_OFS_CNT_MID)) begin
      rd_byte = cnt_r[15:8];
    end else if (hit(io_req.addr, pm_base_config_pair, `PMTMR_OFS_CNT_HIGH)) begin
      rd_byte = cnt_r[23:16];
    end else if (hit(io_req.addr, pm_base_config_pair, `PMTMR_OFS_CTL_RSVD_A) ||
                 hit(io_req.addr, pm_base_config_pair, `PMTMR_OFS_CTL_RSVD_B)) begin
      rd_byte = `PMTMR_RSVD_VALUE;
    end else begin
      rd_sel = 1'b0;
    end
  end

  // writes are decoded nowhere: every byte here is read-only or reserved
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata  <= `PMTMR_RST_BYTE;
      io_rd_hit <= 1'b0;
    end else begin
      io_rd_hit <= io_req.rd && rd_sel;
      if (io_req.rd && rd_sel) begin
        io_rdata <= rd_byte;
      end
    end
  end

endmodule

// ==== verification/pmtmr_sva.sv ====
// port assertions for the power-management timer
`timescale 1ns/1ps
module pmtmr_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // inputs
  input wire logic        working_state,
  input wire logic [15:0] pm_base_config_pair,
  input wire pmtmr_pkg::pmtmr_io_req_t io_req,
  input wire logic        timer_event_enable,
  // outputs
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rd_hit,
  input wire logic        timer_top_bit_toggle_flag,
  input wire logic        sci_b,
  input wire logic [23:0] timer_count_value
);
  wire [15:0] ofs = io_req.addr - pm_base_config_pair;
  wire        rd  = io_req.rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  read_hit_a: assert property (rd && ofs >= 16'h6 && ofs <= 16'ha |=> io_rd_hit)
    else $error("read not answered");
  rsvd_zero_a: assert property (rd && ofs[15:1] == 15'h3 |=> io_rdata == 8'h00)
    else $error("reserved byte not zero");
  low_byte_a: assert property (
    rd && ofs == 16'h8 |=> io_rdata == $past(timer_count_value[7:0]))
    else $error("low byte wrong");
  mid_byte_a: assert property (
    rd && ofs == 16'h9 |=> io_rdata == $past(timer_count_value[15:8]))
    else $error("mid byte wrong");
  high_byte_a: assert property (
    rd && ofs == 16'ha |=> io_rdata == $past(timer_count_value[23:16]))
    else $error("high byte wrong");
  count_step_a: assert property (
    $changed(timer_count_value) |-> timer_count_value == $past(timer_count_value) + 24'h1)
    else $error("count jumped");
  tick_gap_a: assert property ($changed(timer_count_value) |=> $stable(timer_count_value)[*8])
    else $error("count too fast");
  work_hold_a: assert property (!working_state [*2] |=> $stable(timer_count_value))
    else $error("count moved when idle");
  flag_set_a: assert property ($changed(timer_count_value[23]) |-> timer_top_bit_toggle_flag)
    else $error("toggle flag not set");
  sci_on_a: assert property (timer_event_enable && timer_top_bit_toggle_flag |=> !sci_b)
    else $error("sci not raised");
  cover property (rd && ofs == 16'h8 ##1 io_rd_hit);
  cover property ($changed(timer_count_value));
  cover property (!working_state ##1 working_state);
endmodule
bind pmtmr_top pmtmr_sva u_sva (.clk, .rst_b, .working_state, .pm_base_config_pair,
  .io_req, .timer_event_enable, .io_rdata, .io_rd_hit, .timer_top_bit_toggle_flag,
  .sci_b, .timer_count_value);

// ==== verification/pmtmr_host.sv ====
// host software model issuing i/o cycles to the timer bytes
`timescale 1ns/1ps
module pmtmr_host (
  // clock
  input wire logic        clk,
  // i/o cycle
  output pmtmr_pkg::pmtmr_io_req_t io_req,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rd_hit
);
  initial io_req = '0;
  // one cycle launched and released on falling edges
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q, output logic h);
    @(negedge clk);
    io_req = '{addr: a, rd: !w, wr: w, wdata: d};
    @(negedge clk);
    // released lines show no stale value
    io_req = '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
    q = io_rdata;
    h = io_rd_hit;
  endtask
endmodule

// ==== verification/pmtmr_bench.sv ====
// self-checking bench for the power-management timer
`timescale 1ns/1ps
`include "pmtmr_params.svh"
module pmtmr_bench;
  logic        clk = 0, rst_b = 0, work = 1, pin = 0, run_pin = 1, en = 0, h, hit;
  logic        flag, sci_b, stop;
  logic [7:0]  q, rdata;
  logic [15:0] base = 16'h0;
  pmtmr_pkg::pmtmr_io_req_t req;
  int          err_count = 0, check_count = 0, seed = 80415, i, run_cyc = 0;
  logic [31:0] a, b;
  pmtmr_top dut (.clk, .rst_b, .working_state(work), .chip_input_clock_pin(pin),
    .pm_base_config_pair(base), .io_req(req), .io_rdata(rdata), .io_rd_hit(hit),
    .timer_event_enable(en), .timer_status_clear(1'b0), .timer_top_bit_toggle_flag(flag),
    .sci_b, .timer_count_value(), .chip_clock_stopped(stop));
  pmtmr_host host (.clk, .io_req(req), .io_rdata(rdata), .io_rd_hit(hit));
  initial forever #12.5 clk = ~clk;
  always @(negedge clk) if (run_pin) pin <= ~pin;
  always @(posedge clk) if (rst_b && work && run_pin) run_cyc++;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // frozen first so the three bytes cannot tear
  // four-state so an unknown byte cannot pass as zero
  task automatic rd_cnt(output logic [31:0] v);
    work = 0;
    repeat (2) @(negedge clk);
    v = '0;
    for (int k = 0; k < 3; k++) begin
      host.cyc(base + 16'h8 + k[15:0], 1'b0, 8'h00, q, h);
      v = v | ({24'h000000, q} << (8 * k));
    end
  endtask
  // model count from cycles spent running; slack for divider phase and stop lag
  task automatic chk_cnt(logic [31:0] v);
    longint e;
    e = longint'(run_cyc) * `PMTMR_TIMEBASE_HZ / `PMTMR_CLK_HZ;
    chk("count vs model", v >= e - 4 && v <= e + 4, 1);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    err_count++;
    finish_test;
  end
  initial begin
    base = 16'($random(seed));
    repeat (6) @(negedge clk);
    rst_b = 1;
    for (i = 6; i <= 10; i++) begin
      host.cyc(base + i[15:0], 1'b0, 8'h00, q, h);
      chk("reset byte", {h, q}, 9'h100);
    end
    $display("reset test done");
    repeat (2000) @(negedge clk);
    rd_cnt(a);
    chk_cnt(a);
    host.cyc(base + 16'h5, 1'b0, 8'h00, q, h);
    chk("unmapped hit", h, 1'b0);
    for (i = 6; i <= 10; i++) host.cyc(base + i[15:0], 1'b1, 8'($random(seed)), q, h);
    rd_cnt(b);
    chk("count after writes", b, a);
    host.cyc(base + 16'h7, 1'b0, 8'h00, q, h);
    chk("reserved byte", {h, q}, 9'h100);
    $display("io test done");
    work = 1;
    run_pin = 0;
    repeat (40) @(negedge clk);
    chk("pin stop seen", stop, 1'b1);
    rd_cnt(a);
    work = 1;
    repeat (300) @(negedge clk);
    rd_cnt(b);
    chk("held while stopped", b, a);
    work = 1;
    run_pin = 1;
    en = 1;
    repeat (3000) @(negedge clk);
    rd_cnt(b);
    chk_cnt(b);
    chk("toggle flag", flag, 1'b0);
    chk("sci level", sci_b, 1'b1);
    $display("stop test done");
    finish_test;
  end
endmodule
